// file: pkg/dmhbs_pkg.sv
// Constants for the dual mode host bus slave.
// Assumes a synchronous host bus sampled on pclk.
package dmhbs_pkg;
  // =========================================
  // Register offsets (APB byte addresses)
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_RETRACE = 12'h004;
  localparam logic [11:0] ADDR_ROMCFG = 12'h008;
  localparam logic [11:0] ADDR_ROMWIN = 12'h00c;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  localparam logic [11:0] ADDR_WAITS = 12'h014;
  // =========================================
  // Field positions
  localparam int CTRL_MODE_BIT = 0;
  localparam int RET_CLR_BIT = 4;
  localparam int RET_IEN_BIT = 5;
  localparam int ROMCFG_EN_BIT = 0;
  localparam int ROMWIN_MAP_BIT = 0;
  // =========================================
  // Reset values
  localparam logic [7:0] RETRACE_RST = 8'h00;
  localparam logic ROMCFG_RST = 1'b0;
  localparam logic ROMWIN_RST = 1'b0;
  localparam logic [3:0] WAITS_RST = 4'h2;
  // =========================================
  // Host address windows (20-bit memory space, 16-bit I/O space)
  localparam logic [19:0] ROM_LO = 20'hc0000;
  localparam logic [19:0] ROM_HI = 20'hc7fff;
  localparam logic [19:0] HOLE_LO = 20'hc6000;
  localparam logic [19:0] HOLE_HI = 20'hc67ff;
  localparam logic [15:0] PAGE_PORT = 16'h46e8;
  localparam logic [19:0] VMEM_LO = 20'ha0000;
  localparam logic [19:0] VMEM_HI = 20'hbffff;
  localparam logic [15:0] IO_LO = 16'h03b0;
  localparam logic [15:0] IO_HI = 16'h03df;
  // =========================================
  // Cycle state, Gray coded along the path
  typedef enum logic [1:0] {
    DMHBS_IDLE = 2'b00,
    DMHBS_WAIT = 2'b01,
    DMHBS_DONE = 2'b11
  } dmhbs_state_e;
endpackage

// file: src/dmhbs_strobe_gen.sv
// Count-down strobe helper: one output pulse per start with nonzero len.
// Assumes start is a one-cycle pulse in the pclk domain.
`timescale 1ns/10ps
module dmhbs_strobe_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [3:0] len,
  output logic busy,
  output logic done
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic done_q;
  logic done_d;

  assign cnt_d = start ? len : (cnt_q != 4'h0 ? cnt_q - 4'h1 : 4'h0);
  assign done_d = (cnt_q == 4'h1) && !start;
  assign busy = (cnt_q != 4'h0);
  assign done = done_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end
endmodule

// file: src/dmhbs_top.sv
// Host bus slave front end: decode, lane steering, responses.
// Assumes host pins already synchronous to pclk; APB for setup.
`timescale 1ns/10ps
module dmhbs_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mode_strap,
  input wire logic [16:0] host_addr,
  input wire logic [2:0] host_upper_addr,
  input wire logic byte_high_enable_n,
  input wire logic memory_decode_enable,
  input wire logic io_decode_enable,
  input wire logic latch_or_setup,
  input wire logic mem_read_or_mio,
  input wire logic mem_write_or_s0,
  input wire logic io_read_or_s1,
  input wire logic io_write_or_cmd,
  input wire logic vert_display_end,
  output logic irq_out,
  output logic rom_enable_strobe,
  output logic size16_out,
  output logic ready_out,
  output logic high_byte_buffer_dir,
  output logic low_byte_buffer_dir,
  output logic [19:0] vmem_addr,
  output logic lane_high,
  output logic lane_low
);
  // =========================================
  // Mode strap, caught once after reset release
  logic mode_q;
  logic mode_taken_q;
  logic chan_mode;
  assign chan_mode = mode_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 1'b0;
      mode_taken_q <= 1'b0;
    end else if (!mode_taken_q) begin
      mode_q <= mode_strap;
      mode_taken_q <= 1'b1;
    end
  end

  // =========================================
  // Software registers
  logic [7:0] retrace_q;
  logic romcfg_q;
  logic romwin_q;
  logic [3:0] waits_q;
  logic irq_pend_q;

  // =========================================
  // Pin decoding per mode
  logic mem_rd;
  logic mem_wr;
  logic io_rd;
  logic io_wr;
  logic cyc_active;
  logic cmd_low;
  logic decode_ok_mem;
  logic decode_ok_io;

  // Channel: M/IO high mem, S0 low write, S1 low read, CMD low valid
  assign cmd_low = chan_mode && !io_write_or_cmd;
  assign mem_rd = chan_mode ? (cmd_low && mem_read_or_mio && !io_read_or_s1)
    : !mem_read_or_mio;
  assign mem_wr = chan_mode ? (cmd_low && mem_read_or_mio && !mem_write_or_s0)
    : !mem_write_or_s0;
  assign io_rd = chan_mode ? (cmd_low && !mem_read_or_mio && !io_read_or_s1)
    : !io_read_or_s1;
  assign io_wr = chan_mode ? (cmd_low && !mem_read_or_mio && !mem_write_or_s0)
    : !io_write_or_cmd;
  assign cyc_active = mem_rd || mem_wr || io_rd || io_wr;

  // Latch/setup pin is unused: no address capture or decode use here
  // Memory decode needs the external enable; channel also io_decode_enable
  assign decode_ok_mem = memory_decode_enable &&
    (!chan_mode || io_decode_enable);
  assign decode_ok_io = chan_mode ? io_decode_enable
    : !io_decode_enable;

  // =========================================
  // Address windows
  function automatic logic in_range(input logic [19:0] a,
                                    input logic [19:0] lo,
                                    input logic [19:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic in_io_range(input logic [15:0] a,
                                       input logic [15:0] lo,
                                       input logic [15:0] hi);
    in_io_range = (a >= lo) && (a <= hi);
  endfunction

  logic [19:0] mem_a;
  logic [15:0] io_a;
  logic hit_vmem;
  logic hit_rom;
  logic hit_hole;
  logic hit_io;
  logic hit_page;
  logic rom_sel;
  logic vmem_cyc;
  logic io_cyc;

  assign mem_a = {host_upper_addr, host_addr};
  assign io_a = host_addr[15:0];
  assign hit_vmem = in_range(mem_a, dmhbs_pkg::VMEM_LO, dmhbs_pkg::VMEM_HI);
  assign hit_rom = in_range(mem_a, dmhbs_pkg::ROM_LO, dmhbs_pkg::ROM_HI);
  assign hit_hole = in_range(mem_a, dmhbs_pkg::HOLE_LO, dmhbs_pkg::HOLE_HI);
  assign hit_io = in_io_range(io_a, dmhbs_pkg::IO_LO, dmhbs_pkg::IO_HI);
  assign hit_page = (io_a == dmhbs_pkg::PAGE_PORT);
  assign rom_sel = decode_ok_mem && (mem_rd || mem_wr) && hit_rom &&
    romcfg_q && !(hit_hole && romwin_q);
  assign vmem_cyc = decode_ok_mem && (mem_rd || mem_wr) && hit_vmem;
  assign io_cyc = decode_ok_io && (io_rd || io_wr) && hit_io;

  // =========================================
  // Byte lanes
  logic word16;
  assign word16 = !host_addr[0] && !byte_high_enable_n;

  // =========================================
  // Page port strobe: single pulse on write start
  logic page_wr;
  logic page_wr_q;
  assign page_wr = decode_ok_io && io_wr && hit_page;

  // =========================================
  // Wait-state sequencer for video memory cycles
  dmhbs_pkg::dmhbs_state_e st_q;
  dmhbs_pkg::dmhbs_state_e st_d;
  logic wait_start;
  logic wait_busy;
  logic wait_done;
  logic waits_zero;
  assign waits_zero = (waits_q == 4'h0);

  always_comb begin
    st_d = st_q;
    case (st_q)
      dmhbs_pkg::DMHBS_IDLE: begin
        if (vmem_cyc) st_d = dmhbs_pkg::DMHBS_WAIT;
      end
      dmhbs_pkg::DMHBS_WAIT: begin
        if (!cyc_active) st_d = dmhbs_pkg::DMHBS_IDLE;
        else if (wait_done || waits_zero) st_d = dmhbs_pkg::DMHBS_DONE;
      end
      dmhbs_pkg::DMHBS_DONE: begin
        if (!cyc_active) st_d = dmhbs_pkg::DMHBS_IDLE;
      end
      default: st_d = dmhbs_pkg::DMHBS_IDLE;
    endcase
  end
  assign wait_start = (st_q == dmhbs_pkg::DMHBS_IDLE) && vmem_cyc;

  dmhbs_strobe_gen u_waits (
    .pclk(pclk),
    .presetn(presetn),
    .start(wait_start),
    .len(waits_q),
    .busy(wait_busy),
    .done(wait_done)
  );

  // Ready low only while a video memory cycle waits; I/O and ROM never
  // Low from the decode edge until the counter reports done: waits + 1
  logic wait_hold;
  logic ready_d;
  assign wait_hold = (st_q == dmhbs_pkg::DMHBS_WAIT) && !wait_done;
  assign ready_d = waits_zero || !(wait_start || wait_hold);

  // =========================================
  // Pin outputs, all registered
  logic irq_d;
  logic rom_d;
  logic size16_d;
  logic rd_dir_d;
  logic page_pulse;
  logic card_hit;
  assign page_pulse = page_wr && !page_wr_q;
  assign card_hit = vmem_cyc || io_cyc;
  assign irq_d = (retrace_q[dmhbs_pkg::RET_IEN_BIT] && irq_pend_q)
    ^ chan_mode;
  // Channel mode: feedback on any card hit, active low
  assign rom_d = chan_mode ? !card_hit
    : !(rom_sel || page_pulse);
  assign size16_d = chan_mode ? !(card_hit && word16)
    : !(vmem_cyc && word16);
  assign rd_dir_d = !((mem_rd && (vmem_cyc || rom_sel)) ||
    (io_rd && io_cyc));

  // Cycle state and page edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= dmhbs_pkg::DMHBS_IDLE;
      page_wr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      page_wr_q <= page_wr;
    end
  end

  // Host responses; reset levels are the AT mode inactive ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_out <= 1'b0;
      rom_enable_strobe <= 1'b1;
      size16_out <= 1'b1;
      ready_out <= 1'b1;
    end else begin
      irq_out <= irq_d;
      rom_enable_strobe <= rom_d;
      size16_out <= size16_d;
      ready_out <= ready_d;
    end
  end

  // Buffer directions, address and lanes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_byte_buffer_dir <= 1'b1;
      low_byte_buffer_dir <= 1'b1;
      vmem_addr <= 20'h00000;
      lane_high <= 1'b0;
      lane_low <= 1'b0;
    end else begin
      high_byte_buffer_dir <= rd_dir_d;
      low_byte_buffer_dir <= rd_dir_d;
      vmem_addr <= mem_a;
      lane_high <= cyc_active && !byte_high_enable_n;
      lane_low <= cyc_active && !host_addr[0];
    end
  end

  // =========================================
  // APB slave, zero wait states
  logic apb_wr;
  logic apb_rd;
  logic sel_ctrl;
  logic sel_ret;
  logic sel_romcfg;
  logic sel_romwin;
  logic sel_status;
  logic sel_waits;
  logic unmapped;
  logic ret_clear;
  logic [31:0] rdata_d;

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;
  assign sel_ctrl = (paddr == dmhbs_pkg::ADDR_CTRL);
  assign sel_ret = (paddr == dmhbs_pkg::ADDR_RETRACE);
  assign sel_romcfg = (paddr == dmhbs_pkg::ADDR_ROMCFG);
  assign sel_romwin = (paddr == dmhbs_pkg::ADDR_ROMWIN);
  assign sel_status = (paddr == dmhbs_pkg::ADDR_STATUS);
  assign sel_waits = (paddr == dmhbs_pkg::ADDR_WAITS);
  assign unmapped = !(sel_ctrl || sel_ret || sel_romcfg || sel_romwin ||
    sel_status || sel_waits);
  assign ret_clear = apb_wr && sel_ret && pwdata[dmhbs_pkg::RET_CLR_BIT];

  always_comb begin
    if (sel_ctrl) rdata_d = {31'h0, mode_q};
    else if (sel_ret) rdata_d = {24'h0, retrace_q};
    else if (sel_romcfg) rdata_d = {31'h0, romcfg_q};
    else if (sel_romwin) rdata_d = {31'h0, romwin_q};
    else if (sel_status) rdata_d = {27'h0, st_q, wait_busy, irq_pend_q,
      mode_q};
    else if (sel_waits) rdata_d = {28'h0, waits_q};
    else rdata_d = 32'h0;
  end

  // Event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pend_q <= 1'b0;
    end else if (vert_display_end) begin
      irq_pend_q <= 1'b1;
    end else if (ret_clear) begin
      irq_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      retrace_q <= dmhbs_pkg::RETRACE_RST;
      romcfg_q <= dmhbs_pkg::ROMCFG_RST;
      romwin_q <= dmhbs_pkg::ROMWIN_RST;
      waits_q <= dmhbs_pkg::WAITS_RST;
    end else if (apb_wr) begin
      if (sel_ret) retrace_q <= pwdata[7:0];
      if (sel_romcfg) romcfg_q <= pwdata[dmhbs_pkg::ROMCFG_EN_BIT];
      if (sel_romwin) romwin_q <= pwdata[dmhbs_pkg::ROMWIN_MAP_BIT];
      if (sel_waits) waits_q <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      if (apb_rd) prdata <= rdata_d;
      pready <= psel && !penable;
      pslverr <= psel && !penable && unmapped;
    end
  end
endmodule

// file: testbench/dmhbs_top_asserts.sv
// Checker on the host bus slave top ports.
// Assumes a bind to dmhbs_top; AT checks gate on mode_strap low.
`timescale 1ns/10ps
module dmhbs_top_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic mode_strap,
  input wire logic [16:0] host_addr,
  input wire logic [2:0] host_upper_addr,
  input wire logic byte_high_enable_n,
  input wire logic mem_read_or_mio,
  input wire logic mem_write_or_s0,
  input wire logic io_read_or_s1,
  input wire logic io_write_or_cmd,
  input wire logic vert_display_end,
  input wire logic irq_out,
  input wire logic rom_enable_strobe,
  input wire logic size16_out,
  input wire logic ready_out,
  input wire logic high_byte_buffer_dir,
  input wire logic low_byte_buffer_dir,
  input wire logic [19:0] vmem_addr
);
  // ==========================================
  // Properties
  wire at_m = !mode_strap;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  hb_dir_read_a: assert property (at_m && !high_byte_buffer_dir
    |-> !$past(mem_read_or_mio) || !$past(io_read_or_s1))
    else $error("high dir low outside a read");
  lb_dir_read_a: assert property (at_m && !low_byte_buffer_dir
    |-> !$past(mem_read_or_mio) || !$past(io_read_or_s1))
    else $error("low dir low outside a read");
  io_no_wait_a: assert property (at_m && !ready_out
    |-> $past(io_read_or_s1) && $past(io_write_or_cmd))
    else $error("wait state on an io cycle");
  wait_bound_a: assert property ($fell(ready_out)
    |-> ##[1:17] ready_out)
    else $error("wait state too long");
  rom_cause_a: assert property (at_m && !rom_enable_strobe
    |-> !$past(mem_read_or_mio) || !$past(mem_write_or_s0)
      || !$past(io_write_or_cmd))
    else $error("rom strobe without access");
  word_size_a: assert property (at_m && !size16_out
    |-> !$past(byte_high_enable_n) && !$past(host_addr[0]))
    else $error("size16 without word access");
  irq_cause_a: assert property ($rose(irq_out) && at_m
    |-> $past(vert_display_end) || $past(vert_display_end, 2)
      || $past(vert_display_end, 3))
    else $error("irq without retrace end");
  upper_addr_a: assert property (at_m && !ready_out
    |-> vmem_addr[19:17] == $past(host_upper_addr))
    else $error("upper address not passed");
  apb_ready_a: assert property (psel && penable |-> pready)
    else $error("apb access without ready");
endmodule

bind dmhbs_top dmhbs_top_asserts u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready),
  .mode_strap(mode_strap), .host_addr(host_addr),
  .host_upper_addr(host_upper_addr),
  .byte_high_enable_n(byte_high_enable_n),
  .mem_read_or_mio(mem_read_or_mio), .mem_write_or_s0(mem_write_or_s0),
  .io_read_or_s1(io_read_or_s1), .io_write_or_cmd(io_write_or_cmd),
  .vert_display_end(vert_display_end), .irq_out(irq_out),
  .rom_enable_strobe(rom_enable_strobe), .size16_out(size16_out),
  .ready_out(ready_out), .high_byte_buffer_dir(high_byte_buffer_dir),
  .low_byte_buffer_dir(low_byte_buffer_dir), .vmem_addr(vmem_addr));

// file: testbench/dmhbs_host_model.sv
// AT mode host bus master: one strobe cycle per go.
// Assumes go is a one-cycle request; waits on ready_out.
`timescale 1ns/10ps
module dmhbs_host_model (
  input wire logic pclk,
  input wire logic go,
  input wire logic [1:0] kind,
  input wire logic [19:0] addr,
  input wire logic bhe_n,
  input wire logic ready_out,
  output logic [19:0] host_a,
  output logic byte_high_enable_n,
  output logic [3:0] strb_n,
  output logic busy
);
  // ==========================================
  // Cycle engine
  initial begin
    strb_n = 4'hf;
    busy = 1'b0;
    host_a = 20'h00000;
    byte_high_enable_n = 1'b1;
    forever begin
      @(posedge pclk);
      if (go) begin
        busy <= 1'b1;
        host_a <= addr;
        byte_high_enable_n <= bhe_n;
        strb_n[kind] <= 1'b0;
        repeat (3) @(posedge pclk);
        while (ready_out !== 1'b1) @(posedge pclk);
        strb_n <= 4'hf;
        // Released lines show garbage, not the old value
        host_a <= ~addr;
        byte_high_enable_n <= ~bhe_n;
        busy <= 1'b0;
      end
    end
  end
endmodule

// file: testbench/dmhbs_tb_top.sv
// Self-checking bench for the host bus slave top.
// Assumes the AT host model and APB master tasks below.
`timescale 1ns/10ps
module dmhbs_tb_top;
  // ==========================================
  // Signals
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, er, irq, rom, s16, rdy, hdir, ldir, hl, ll;
  logic strap = 0, mde = 1, ioe = 1, los = 0, vde = 0, go = 0, bhe = 1;
  logic [1:0] kind = 0;
  logic [19:0] ha = 0, hp, vma;
  logic [3:0] sn;
  logic hbe, hbusy;
  logic [31:0] seed = 32'h25aaa689;
  int n_rdy, n_rom, n_dir, n_s16, n_hl, n_ll, w_m;
  int mismatches = 0, total_checks = 0;
  logic [19:0] ra [4] = '{20'hc0000, 20'hc6000, 20'hc6000, 20'hc7ffe};
  logic rw [4] = '{1'b0, 1'b0, 1'b1, 1'b1};

  dmhbs_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_strap(strap), .host_addr(hp[16:0]),
    .host_upper_addr(hp[19:17]), .byte_high_enable_n(hbe),
    .memory_decode_enable(mde), .io_decode_enable(ioe),
    .latch_or_setup(los), .mem_read_or_mio(sn[0]),
    .mem_write_or_s0(sn[1]), .io_read_or_s1(sn[2]),
    .io_write_or_cmd(sn[3]), .vert_display_end(vde), .irq_out(irq),
    .rom_enable_strobe(rom), .size16_out(s16), .ready_out(rdy),
    .high_byte_buffer_dir(hdir), .low_byte_buffer_dir(ldir),
    .vmem_addr(vma), .lane_high(hl), .lane_low(ll));
  dmhbs_host_model u_host (.pclk(pclk), .go(go), .kind(kind),
    .addr(ha), .bhe_n(bhe), .ready_out(rdy), .host_a(hp),
    .byte_high_enable_n(hbe), .strb_n(sn), .busy(hbusy));

  always #12.5 pclk = ~pclk;
  // Count at the falling edge, clear of the launch edge
  always @(negedge pclk) begin
    n_rdy += int'(rdy === 1'b0);
    n_rom += int'(rom === 1'b0);
    n_dir += int'(ldir === 1'b0 && hdir === 1'b0);
    n_s16 += int'(s16 === 1'b0);
    n_hl += int'(hl === 1'b1);
    n_ll += int'(ll === 1'b1);
  end
  // ==========================================
  // Tasks
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    total_checks++;
    if (seen !== ex) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task cyc(input logic [1:0] k, input logic [19:0] a, input logic b);
    n_rdy = 0;
    n_rom = 0;
    n_dir = 0;
    n_s16 = 0;
    n_hl = 0;
    n_ll = 0;
    kind <= k;
    ha <= a;
    bhe <= b;
    los <= 1'(rnd());
    go <= 1;
    @(posedge pclk);
    go <= 0;
    do @(posedge pclk); while (hbusy);
    repeat (2) @(posedge pclk);
  endtask
  task pulse_end();
    vde <= 1;
    @(posedge pclk);
    vde <= 0;
    repeat (4) @(posedge pclk);
  endtask
  // ==========================================
  // Sequence
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    results();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    check("idle", {rdy, hdir, ldir, rom, s16, irq}, 32'h3e);
    apb(0, dmhbs_pkg::ADDR_WAITS, 0);
    check("waits", rd, 32'h2);
    apb(0, 12'h0f0, 0);
    check("unmapped_err", er, 1);
    check("unmapped", rd, 0);
    for (int i = 0; i < 3; i++) begin
      w_m = (i == 0) ? 0 : int'(rnd() & 15);
      apb(1, dmhbs_pkg::ADDR_WAITS, w_m);
      // Odd byte on the last pass so both lanes are seen idle too
      cyc(0, (20'ha0000 + (rnd() & 20'h1fffe)) | 20'(i == 2), i == 2);
      check("waits", n_rdy, (w_m == 0) ? 0 : w_m + 1);
      check("lane_hi", n_hl > 0, i != 2);
      check("lane_lo", n_ll > 0, i != 2);
      check("word", n_s16 > 0, i != 2);
      check("rd_dir", n_dir > 0, 1);
    end
    cyc(1, 20'hb0000, 0);
    check("wr_dir", n_dir, 0);
    mde <= 0;
    cyc(0, 20'ha0000, 0);
    check("no_dec", n_s16 + n_rdy, 0);
    mde <= 1;
    apb(1, dmhbs_pkg::ADDR_ROMCFG, 1);
    for (int i = 0; i < 4; i++) begin
      apb(1, dmhbs_pkg::ADDR_ROMWIN, rw[i]);
      cyc(0, ra[i], 1);
      check("rom", n_rom > 0, !(rw[i] && ra[i] >= dmhbs_pkg::HOLE_LO
        && ra[i] <= dmhbs_pkg::HOLE_HI));
      check("rom_rdy", n_rdy, 0);
    end
    apb(1, dmhbs_pkg::ADDR_ROMCFG, 0);
    cyc(0, 20'hc0000, 1);
    check("rom_off", n_rom, 0);
    ioe <= 0;
    cyc(3, 20'he46e8, 1);
    check("page", n_rom, 1);
    check("io_rdy", n_rdy, 0);
    cyc(2, 20'h003c0, 1);
    check("io_dir", n_dir > 0, 1);
    ioe <= 1;
    cyc(3, 20'h046e8, 1);
    check("aen_off", n_rom, 0);
    apb(1, dmhbs_pkg::ADDR_RETRACE, 32'h20);
    pulse_end();
    repeat (8) @(posedge pclk);
    check("irq_set", irq, 1);
    apb(1, dmhbs_pkg::ADDR_RETRACE, 32'h30);
    repeat (2) @(posedge pclk);
    check("irq_clr", irq, 0);
    apb(1, dmhbs_pkg::ADDR_RETRACE, 0);
    pulse_end();
    check("irq_mask", irq, 0);
    presetn <= 0;
    strap <= 1;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    repeat (3) @(posedge pclk);
    check("ch_irq", irq, 1);
    results();
  end
endmodule
